// [logic/fcc_pkg.sv]
package fcc_pkg;

    // ****************************************************************
    // Register port map
    // ****************************************************************
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFS_CONTROL_STATUS = 4'h0;
    localparam logic [3:0] OFS_IMPLEMENTATION = 4'h4;
    localparam logic [3:0] OFS_LAST_EXCEPTION = 4'h8;
    localparam logic [31:0] CONTROL_STATUS_RST = 32'h0000_0000;
    localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

    // ****************************************************************
    // Control/status field positions
    // ****************************************************************
    localparam int CSR_FLAG_I = 2;
    localparam int CSR_FLAG_V = 6;
    localparam int CSR_EN_V = 11;
    localparam int CSR_CAUSE_I = 12;
    localparam int CSR_CAUSE_V = 16;
    localparam int CSR_CAUSE_HI = 17;
    localparam int CSR_NAN_SEL = 18;
    localparam int CSR_FLUSH_SUB = 24;

    // ****************************************************************
    // Control read selectors and release levels
    // ****************************************************************
    localparam logic [4:0] SEL_IMPL = 5'h00;
    localparam logic [4:0] SEL_MODE_SWITCH = 5'h01;
    localparam logic [4:0] SEL_MODE_CLEAR = 5'h04;
    localparam logic [4:0] SEL_COND = 5'h19;
    localparam logic [4:0] SEL_EXC = 5'h1A;
    localparam logic [4:0] SEL_ENA = 5'h1C;
    localparam logic [4:0] SEL_CSR = 5'h1F;
    localparam logic [2:0] REL_TRAPS = 3'h2;

    // ****************************************************************
    // Number formats and conversion limits
    // ****************************************************************
    localparam logic signed [12:0] SP_BIAS = 13'sh007F;
    localparam logic signed [12:0] DP_BIAS = 13'sh03FF;
    localparam logic signed [12:0] CVT_SHIFT_OFS = 13'sh000C;
    localparam logic signed [12:0] CVT_MAX_EXP = 13'sh003F;
    localparam logic [64:0] WORD_POS_LIM = 65'h0_0000_0000_7FFF_FFFF;
    localparam logic [64:0] WORD_NEG_LIM = 65'h0_0000_0000_8000_0000;
    localparam logic [64:0] LONG_POS_LIM = 65'h0_7FFF_FFFF_FFFF_FFFF;
    localparam logic [64:0] LONG_NEG_LIM = 65'h0_8000_0000_0000_0000;
    localparam logic [63:0] WORD_POS_MAX = 64'h0000_0000_7FFF_FFFF;
    localparam logic [63:0] WORD_NEG_MIN = 64'hFFFF_FFFF_8000_0000;
    localparam logic [63:0] LONG_POS_MAX = 64'h7FFF_FFFF_FFFF_FFFF;
    localparam logic [63:0] LONG_NEG_MIN = 64'h8000_0000_0000_0000;

    // ****************************************************************
    // Class mask bit positions
    // ****************************************************************
    localparam int CLS_SNAN = 0;
    localparam int CLS_QNAN = 1;
    localparam int CLS_NEG_INF = 2;
    localparam int CLS_POS_INF = 6;

    typedef enum logic [2:0] {
        FCC_OP_NONE = 3'b000,
        FCC_OP_CEIL_WORD = 3'b001,
        FCC_OP_CEIL_LONG = 3'b010,
        FCC_OP_CTRL_READ = 3'b011,
        FCC_OP_CP2_READ = 3'b100,
        FCC_OP_CLASS = 3'b101
    } fcc_op_t;

    typedef enum logic [1:0] {
        FCC_FMT_SINGLE = 2'b00,
        FCC_FMT_DOUBLE = 2'b01
    } fcc_fmt_t;

    typedef enum logic [1:0] {
        FCC_EXC_NONE = 2'b00,
        FCC_EXC_COP_UNUSABLE = 2'b01,
        FCC_EXC_RESERVED = 2'b10,
        FCC_EXC_FP_INVALID = 2'b11
    } fcc_exc_t;

    typedef struct packed {
        logic valid;
        fcc_op_t op;
        logic [1:0] fmt;
        logic [4:0] sel;
        logic [4:0] dst;
        logic [63:0] operand;
    } fcc_req_t;

    typedef struct packed {
        logic valid;
        logic wr;
        logic to_gpr;
        fcc_op_t op;
        fcc_exc_t exc;
        logic inexact;
        logic [4:0] dst;
        logic [63:0] data;
    } fcc_res_t;

endpackage

// [logic/fcc_top.sv]
`timescale 1ns/1ps
module fcc_top #(
    parameter logic [31:0] IMPL_WORD = 32'h0000_0100 // Value is arbitrary.
) (
    // Clock, reset and enable
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    // Register port
    input wire logic [fcc_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // Pipeline request and answer
    input wire fcc_pkg::fcc_req_t req_i,
    output fcc_pkg::fcc_res_t res_o,
    // Core configuration
    input wire logic cp1_usable_i,
    input wire logic cp2_usable_i,
    input wire logic fp_register_mode_i,
    input wire logic [2:0] isa_release_level_i,
    // Coprocessor 2 control word fetch
    output logic [4:0] cp2_sel_o,
    input wire logic [31:0] cp2_data_i,
    // Live control/status word
    output logic [31:0] fp_control_status_o
);
    import fcc_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    logic [31:0] fp_control_status_r;
    logic [31:0] fp_control_status_nxt;
    logic [31:0] reg_rdata_r;
    logic [1:0] last_exc_r;
    fcc_res_t res_r;
    fcc_res_t res_nxt;
    logic acc;

    assign acc = req_i.valid && clk_en_i;
    assign cp2_sel_o = req_i.sel;
    assign res_o = res_r;
    assign reg_rdata_o = reg_rdata_r;
    assign fp_control_status_o = fp_control_status_r;

    // ****************************************************************
    // Ceiling conversion datapath
    // ****************************************************************
    logic cv_sign;
    logic cv_nan;
    logic cv_inf;
    logic cv_big;
    logic cv_frac;
    logic cv_ovf;
    logic cv_invalid;
    logic cv_inexact;
    logic [52:0] cv_mant;
    logic signed [12:0] cv_exp;
    logic [127:0] cv_shifted;
    logic [64:0] cv_mag;
    logic [63:0] cv_value;
    logic [63:0] cv_default;
    logic is_long;

    assign is_long = (req_i.op == FCC_OP_CEIL_LONG);

    always_comb begin
        cv_sign = 1'b0;
        cv_nan = 1'b0;
        cv_inf = 1'b0;
        cv_mant = '0;
        cv_exp = '0;
        if (req_i.fmt == FCC_FMT_SINGLE) begin
            cv_sign = req_i.operand[31];
            cv_nan = (&req_i.operand[30:23]) && (|req_i.operand[22:0]);
            cv_inf = (&req_i.operand[30:23]) && !(|req_i.operand[22:0]);
            cv_mant = {(|req_i.operand[30:23]), req_i.operand[22:0], 29'h0000_0000};
            cv_exp = (req_i.operand[30:23] == 8'h00) ? (13'sh0001 - SP_BIAS)
                   : ($signed({5'h00, req_i.operand[30:23]}) - SP_BIAS);
        end else begin
            cv_sign = req_i.operand[63];
            cv_nan = (&req_i.operand[62:52]) && (|req_i.operand[51:0]);
            cv_inf = (&req_i.operand[62:52]) && !(|req_i.operand[51:0]);
            cv_mant = {(|req_i.operand[62:52]), req_i.operand[51:0]};
            cv_exp = (req_i.operand[62:52] == 11'h000) ? (13'sh0001 - DP_BIAS)
                   : ($signed({2'h0, req_i.operand[62:52]}) - DP_BIAS);
        end
    end

    // The binary point sits between bits 64 and 63 after the shift.
    always_comb begin
        cv_big = 1'b0;
        cv_shifted = '0;
        cv_frac = 1'b0;
        if (cv_exp < 13'sh0000) begin
            cv_frac = |cv_mant;
        end else if (cv_exp > CVT_MAX_EXP) begin
            cv_big = 1'b1;
        end else begin
            cv_shifted = {75'h0, cv_mant} << 7'(cv_exp + CVT_SHIFT_OFS);
            cv_frac = |cv_shifted[63:0];
        end
        cv_mag = {1'b0, cv_shifted[127:64]} + {64'h0, (cv_frac && !cv_sign)};
        if (is_long) begin
            cv_ovf = cv_big || (cv_sign ? (cv_mag > LONG_NEG_LIM) : (cv_mag > LONG_POS_LIM));
        end else begin
            cv_ovf = cv_big || (cv_sign ? (cv_mag > WORD_NEG_LIM) : (cv_mag > WORD_POS_LIM));
        end
        cv_invalid = cv_nan || cv_inf || cv_ovf;
        cv_inexact = cv_frac && !cv_invalid;
        cv_value = cv_sign ? (64'h0 - cv_mag[63:0]) : cv_mag[63:0];
        if (!is_long) begin
            cv_value = {{32{cv_value[31]}}, cv_value[31:0]};
        end
        if (!fp_control_status_r[CSR_NAN_SEL]) begin
            cv_default = is_long ? LONG_POS_MAX : WORD_POS_MAX;
        end else if (cv_nan) begin
            cv_default = 64'h0;
        end else if (cv_sign) begin
            cv_default = is_long ? LONG_NEG_MIN : WORD_NEG_MIN;
        end else begin
            cv_default = is_long ? LONG_POS_MAX : WORD_POS_MAX;
        end
    end

    // ****************************************************************
    // Control register read and aliases
    // ****************************************************************
    logic [31:0] ctl_word;
    logic ctl_trap;
    logic [31:0] csr;

    assign csr = fp_control_status_r;

    always_comb begin
        ctl_trap = 1'b0;
        ctl_word = 32'h0;
        if (req_i.sel == SEL_IMPL) begin
            ctl_word = IMPL_WORD;
        end else if (req_i.sel == SEL_CSR) begin
            ctl_word = csr;
        end else if (req_i.sel == SEL_COND) begin
            ctl_word = {24'h00_0000, csr[31:25], csr[23]};
        end else if (req_i.sel == SEL_EXC) begin
            ctl_word = {14'h0000, csr[17:12], 5'h00, csr[6:2], 2'h0};
        end else if (req_i.sel == SEL_ENA) begin
            ctl_word = {20'h0_0000, csr[11:7], 4'h0, csr[24], csr[1:0]};
        end else begin
            // Removed mode aliases trap like any missing selector on newer releases.
            ctl_trap = (isa_release_level_i >= REL_TRAPS);
        end
    end

    // ****************************************************************
    // Classification
    // ****************************************************************
    logic [9:0] cls_mask;
    logic cls_sign;
    logic cls_exp_max;
    logic cls_exp_zero;
    logic cls_frac_zero;
    logic cls_quiet;

    // Upper input bits of a single operand are never looked at.
    always_comb begin
        if (req_i.fmt == FCC_FMT_SINGLE) begin
            cls_sign = req_i.operand[31];
            cls_exp_max = &req_i.operand[30:23];
            cls_exp_zero = ~|req_i.operand[30:23];
            cls_frac_zero = ~|req_i.operand[22:0];
            cls_quiet = req_i.operand[22];
        end else begin
            cls_sign = req_i.operand[63];
            cls_exp_max = &req_i.operand[62:52];
            cls_exp_zero = ~|req_i.operand[62:52];
            cls_frac_zero = ~|req_i.operand[51:0];
            cls_quiet = req_i.operand[51];
        end
        cls_mask = '0;
        if (cls_exp_max && !cls_frac_zero) begin
            cls_mask[CLS_QNAN] = cls_quiet;
            cls_mask[CLS_SNAN] = !cls_quiet;
        end else begin
            // Flush-subnormal mode is deliberately not consulted here.
            cls_mask[(cls_sign ? CLS_NEG_INF : CLS_POS_INF) + 0] = cls_exp_max;
            cls_mask[(cls_sign ? CLS_NEG_INF : CLS_POS_INF) + 1] =
                !cls_exp_max && !cls_exp_zero;
            cls_mask[(cls_sign ? CLS_NEG_INF : CLS_POS_INF) + 2] =
                cls_exp_zero && !cls_frac_zero;
            cls_mask[(cls_sign ? CLS_NEG_INF : CLS_POS_INF) + 3] =
                cls_exp_zero && cls_frac_zero;
        end
    end

    // ****************************************************************
    // Result selection
    // ****************************************************************
    logic fmt_ok;
    logic is_ceil;

    assign fmt_ok = (req_i.fmt == FCC_FMT_SINGLE) || (req_i.fmt == FCC_FMT_DOUBLE);
    assign is_ceil = (req_i.op == FCC_OP_CEIL_WORD) || is_long;

    always_comb begin
        res_nxt = '0;
        res_nxt.valid = req_i.valid && (req_i.op != FCC_OP_NONE);
        res_nxt.op = req_i.op;
        res_nxt.dst = req_i.dst;
        res_nxt.wr = 1'b1;
        if (req_i.op == FCC_OP_CP2_READ) begin
            res_nxt.to_gpr = 1'b1;
            if (!cp2_usable_i) begin
                res_nxt.exc = FCC_EXC_COP_UNUSABLE;
            end else begin
                res_nxt.data = {{32{cp2_data_i[31]}}, cp2_data_i};
            end
        end else if (!cp1_usable_i) begin
            res_nxt.exc = FCC_EXC_COP_UNUSABLE;
        end else if (req_i.op == FCC_OP_CTRL_READ) begin
            res_nxt.to_gpr = 1'b1;
            if (ctl_trap) begin
                res_nxt.exc = FCC_EXC_RESERVED;
            end else begin
                res_nxt.data = {{32{ctl_word[31]}}, ctl_word};
            end
        end else if (!fmt_ok) begin
            res_nxt.exc = FCC_EXC_RESERVED;
        end else if (req_i.op == FCC_OP_CLASS) begin
            res_nxt.data = {54'h0, cls_mask};
        end else if (is_ceil) begin
            // Long results are computed alike; in 32-bit register mode software
            // must treat them as unpredictable.
            res_nxt.inexact = cv_inexact;
            if (cv_invalid && csr[CSR_EN_V]) begin
                res_nxt.exc = FCC_EXC_FP_INVALID;
            end else begin
                res_nxt.data = cv_invalid ? cv_default : cv_value;
            end
        end
        if (res_nxt.exc != FCC_EXC_NONE) begin
            res_nxt.wr = 1'b0;
            res_nxt.data = '0;
        end
    end

    logic ceil_live;
    assign ceil_live = acc && is_ceil && cp1_usable_i && fmt_ok;

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            res_r <= '0;
        end else if (clk_en_i) begin
            res_r <= res_nxt;
        end
    end

    // ****************************************************************
    // Control/status register and register port
    // ****************************************************************
    // A flag raised by a conversion wins over a software write in the same cycle.
    always_comb begin
        fp_control_status_nxt = fp_control_status_r;
        if (reg_wr_i && (reg_addr_i == OFS_CONTROL_STATUS)) begin
            fp_control_status_nxt = reg_wdata_i;
        end
        if (ceil_live) begin
            fp_control_status_nxt[CSR_CAUSE_HI:CSR_CAUSE_I] = '0;
            fp_control_status_nxt[CSR_CAUSE_V] = cv_invalid;
            fp_control_status_nxt[CSR_CAUSE_I] = cv_inexact;
            if (cv_invalid) begin
                fp_control_status_nxt[CSR_FLAG_V] = 1'b1;
            end
            if (cv_inexact) begin
                fp_control_status_nxt[CSR_FLAG_I] = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fp_control_status_r <= CONTROL_STATUS_RST;
        end else if (clk_en_i) begin
            fp_control_status_r <= fp_control_status_nxt;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            last_exc_r <= FCC_EXC_NONE;
        end else if (clk_en_i && res_nxt.valid) begin
            last_exc_r <= res_nxt.exc;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rdata_r <= '0;
        end else if (clk_en_i) begin
            if (!reg_rd_i) begin
                reg_rdata_r <= '0;
            end else if (reg_addr_i == OFS_CONTROL_STATUS) begin
                reg_rdata_r <= fp_control_status_r;
            end else if (reg_addr_i == OFS_IMPLEMENTATION) begin
                reg_rdata_r <= IMPL_WORD;
            end else if (reg_addr_i == OFS_LAST_EXCEPTION) begin
                reg_rdata_r <= {30'h0, last_exc_r};
            end else begin
                reg_rdata_r <= READ_UNMAPPED;
            end
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence s_ceil_invalid;
        ceil_live && cv_invalid;
    endsequence

    AST_INV_FLAG: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        s_ceil_invalid |=> fp_control_status_r[CSR_FLAG_V])
        else $error("Invalid conversion did not set the invalid flag.");

    AST_INV_TRAP: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        s_ceil_invalid ##0 csr[CSR_EN_V] |=> !res_r.wr && (res_r.exc == FCC_EXC_FP_INVALID))
        else $error("Enabled invalid conversion wrote a result.");

    AST_LEGACY_DEFAULT: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        s_ceil_invalid ##0 !csr[CSR_EN_V] && !csr[CSR_NAN_SEL] && is_long
        |=> res_r.data == LONG_POS_MAX)
        else $error("Legacy default result is not the positive maximum.");

    AST_NAN_ZERO: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        s_ceil_invalid ##0 cv_nan && !csr[CSR_EN_V] && csr[CSR_NAN_SEL]
        |=> res_r.wr && (res_r.data == 64'h0))
        else $error("NaN default result is not zero.");

    AST_COND_ALIAS: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        acc && cp1_usable_i && (req_i.op == FCC_OP_CTRL_READ) && (req_i.sel == SEL_COND)
        |=> res_r.data[31:0] == {24'h00_0000, $past(csr[31:25]), $past(csr[23])})
        else $error("Condition alias read returned wrong bits.");

    AST_SIGN_EXT: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        res_r.valid && res_r.to_gpr && res_r.wr |-> res_r.data[63:32] == {32{res_r.data[31]}})
        else $error("Control read result is not sign-extended.");

    AST_RELEASE_TRAP: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        acc && cp1_usable_i && (req_i.op == FCC_OP_CTRL_READ)
        && ((req_i.sel == SEL_MODE_SWITCH) || (req_i.sel == SEL_MODE_CLEAR))
        && (isa_release_level_i >= REL_TRAPS) |=> res_r.exc == FCC_EXC_RESERVED)
        else $error("Removed alias read did not trap.");

    AST_CLASS_ONEHOT: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        res_r.valid && (res_r.op == FCC_OP_CLASS) && res_r.wr
        |-> $onehot(res_r.data[9:0]) && (res_r.data[63:10] == '0))
        else $error("Class mask is not a single bit.");

    AST_CLASS_NO_FPE: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        res_r.valid && (res_r.op == FCC_OP_CLASS) |-> res_r.exc != FCC_EXC_FP_INVALID)
        else $error("Classification raised a floating point exception.");

endmodule

// [testbench/fcc_cp2_model.sv]
`timescale 1ns/1ps
module fcc_cp2_model (
    // Selector in, control word out
    input wire logic [4:0] sel_i,
    output logic [31:0] word_o
);
    // The top bit is always set, so a missing sign extension cannot hide.
    assign word_o = {7'h55, 20'hA5C3E, sel_i};
endmodule

// [testbench/fcc_top_tb.sv]
`timescale 1ns/1ps
module fcc_top_tb;
    import fcc_pkg::*;
    localparam logic [31:0] IMPL = 32'h0000_0A5C; // Value is arbitrary.
    localparam logic [63:0] CIN [10] = '{64'h3FC00000, 64'hBFC00000, 64'h40000000,
        64'h3FF8000000000000, 64'h7FC00000, 64'h7FC00000, 64'h7F800000, 64'hFF800000,
        64'h4F000000, 64'hCF000000};
    localparam logic [63:0] COUT [10] = '{64'h2, 64'hFFFFFFFFFFFFFFFF, 64'h2, 64'h2,
        WORD_POS_MAX, 64'h0, WORD_POS_MAX, WORD_NEG_MIN, WORD_POS_MAX, WORD_NEG_MIN};
    localparam logic [9:0] NSEL = 10'h1E0;
    localparam logic [9:0] CIX = 10'h00B;
    localparam logic [9:0] CINV = 10'h1F0;
    localparam logic [63:0] CLS [12] = '{64'h7F800001, 64'h7FC00000, 64'hFF800000,
        64'hBF800000, 64'h80000001, 64'h80000000, 64'h7F800000, 64'h3F800000, 64'h1, 64'h0,
        64'h3FF0000000000000, 64'h8000000000000001};
    localparam logic [4:0] SELS [5] = '{SEL_IMPL, SEL_CSR, SEL_COND, SEL_EXC, SEL_ENA};
    localparam logic [4:0] TRAPS [3] = '{SEL_MODE_SWITCH, SEL_MODE_CLEAR, 5'h05};
    logic clk = 0, rst_b = 0, wr = 0, rd = 0, u1 = 1, u2 = 1, en = 1;
    logic [3:0] addr = 4'h0;
    logic [31:0] wd = 32'h0, rdat, csr, cp2w, lf = 32'h34BA;
    logic [2:0] rel = 3'h2;
    logic [4:0] c2s;
    fcc_req_t req = '0;
    fcc_res_t res;
    int mismatches = 0, n_checks = 0, cyc = 0;

    fcc_top #(.IMPL_WORD(IMPL)) u_dut (.ref_clk_i(clk), .rst_b_i(rst_b), .clk_en_i(en),
        .reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat),
        .req_i(req), .res_o(res), .cp1_usable_i(u1), .cp2_usable_i(u2),
        .fp_register_mode_i(1'b1), .isa_release_level_i(rel), .cp2_sel_o(c2s),
        .cp2_data_i(cp2w), .fp_control_status_o(csr));
    fcc_cp2_model u_cp2 (.sel_i(c2s), .word_o(cp2w));

    initial begin
        forever #50 clk = ~clk;
    end

    function automatic logic [31:0] nx(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    function automatic logic [63:0] alias_of(input logic [4:0] s, input logic [31:0] c);
        logic [31:0] t;
        case (s)
            SEL_IMPL: t = IMPL;
            SEL_COND: t = {24'h0, c[31:25], c[23]};
            SEL_EXC: t = {14'h0, c[17:12], 5'h0, c[6:2], 2'h0};
            SEL_ENA: t = {20'h0, c[11:7], 4'h0, c[24], c[1:0]};
            default: t = c;
        endcase
        return {{32{t[31]}}, t};
    endfunction

    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic bw(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic br(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk("reg_rdata_o", {32'h0, e}, {32'h0, rdat});
    endtask

    task automatic run(input fcc_op_t o, input logic [1:0] f, input logic [4:0] s,
            input logic [63:0] v);
        @(posedge clk);
        req <= '{1'b1, o, f, s, 5'h3, v};
        @(posedge clk);
        req.valid <= 1'b0;
        #1;
    endtask

    task automatic ex(input fcc_exc_t x, input logic [63:0] d);
        chk("res_o.valid", 64'h1, {63'h0, res.valid});
        chk("res_o.exc", {62'h0, x}, {62'h0, res.exc});
        chk("res_o.wr", {63'h0, x == FCC_EXC_NONE}, {63'h0, res.wr});
        chk("res_o.data", d, res.data);
        chk("res_o.dst", 64'h3, {59'h0, res.dst});
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // A hang counts as a mismatch and still reaches the report.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            mismatches = mismatches + 1;
            summarize();
        end
    end

    // ****************************************************************
    // Stimulus and checks
    // ****************************************************************
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        lf = nx(lf);
        bw(OFS_CONTROL_STATUS, lf);
        br(OFS_CONTROL_STATUS, lf);
        bw(OFS_IMPLEMENTATION, ~IMPL);
        br(OFS_IMPLEMENTATION, IMPL);
        br(4'hC, READ_UNMAPPED);
        for (int i = 0; i < 10; i++) begin
            bw(OFS_CONTROL_STATUS, {13'h0, NSEL[i], 18'h0});
            run((i == 3) ? FCC_OP_CEIL_LONG : FCC_OP_CEIL_WORD, {1'b0, i == 3}, 5'h0, CIN[i]);
            ex(FCC_EXC_NONE, COUT[i]);
            chk("inexact", {63'h0, CIX[i]}, {63'h0, res.inexact});
            chk("flag_v", {63'h0, CINV[i]}, {63'h0, csr[CSR_FLAG_V]});
        end
        // Legacy encoding is still selected here, so a long NaN gives the long maximum.
        run(FCC_OP_CEIL_LONG, 2'h1, 5'h0, 64'h7FF8000000000000);
        ex(FCC_EXC_NONE, LONG_POS_MAX);
        chk("flag_v", 64'h1, {63'h0, csr[CSR_FLAG_V]});
        bw(OFS_CONTROL_STATUS, 32'h0000_0800);
        run(FCC_OP_CEIL_WORD, 2'h0, 5'h0, 64'h7F800000);
        ex(FCC_EXC_FP_INVALID, 64'h0);
        chk("flag_v", 64'h1, {63'h0, csr[CSR_FLAG_V]});
        u1 <= 1'b0;
        run(FCC_OP_CEIL_WORD, 2'h0, 5'h0, 64'h3FC00000);
        ex(FCC_EXC_COP_UNUSABLE, 64'h0);
        u1 <= 1'b1;
        lf = nx(lf) | 32'h8000_0000;
        bw(OFS_CONTROL_STATUS, lf);
        foreach (SELS[i]) begin
            run(FCC_OP_CTRL_READ, 2'h0, SELS[i], 64'h0);
            ex(FCC_EXC_NONE, alias_of(SELS[i], lf));
            chk("res_o.to_gpr", 64'h1, {63'h0, res.to_gpr});
        end
        foreach (TRAPS[i]) begin
            run(FCC_OP_CTRL_READ, 2'h0, TRAPS[i], 64'h0);
            ex(FCC_EXC_RESERVED, 64'h0);
        end
        br(OFS_LAST_EXCEPTION, 32'h2);
        rel <= 3'h1;
        run(FCC_OP_CTRL_READ, 2'h0, SEL_MODE_SWITCH, 64'h0);
        ex(FCC_EXC_NONE, 64'h0);
        rel <= 3'h2;
        lf = nx(lf);
        run(FCC_OP_CP2_READ, 2'h0, lf[4:0], 64'h0);
        ex(FCC_EXC_NONE, {32'hFFFFFFFF, 7'h55, 20'hA5C3E, lf[4:0]});
        u2 <= 1'b0;
        run(FCC_OP_CP2_READ, 2'h0, lf[4:0], 64'h0);
        ex(FCC_EXC_COP_UNUSABLE, 64'h0);
        // A low clock enable must leave the previous answer in place.
        u2 <= 1'b1;
        en <= 1'b0;
        run(FCC_OP_CLASS, 2'h0, 5'h0, 64'h0);
        ex(FCC_EXC_COP_UNUSABLE, 64'h0);
        en <= 1'b1;
        // Flush and invalid enable are set: neither may touch a class result.
        bw(OFS_CONTROL_STATUS, 32'h0100_0800);
        for (int i = 0; i < 12; i++) begin
            lf = nx(lf);
            run(FCC_OP_CLASS, {1'b0, i > 9}, 5'h0, (i < 10) ? {lf, CLS[i][31:0]} : CLS[i]);
            ex(FCC_EXC_NONE, 64'h1 << ((i < 10) ? i : 37 - 3 * i));
        end
        run(FCC_OP_CLASS, 2'h2, 5'h0, 64'h0);
        ex(FCC_EXC_RESERVED, 64'h0);
        summarize();
    end
endmodule
